// [inc/icd_regs.vh]
// Register indices, field positions, reset values and source codes of the
// bus interface control block. Definitions only, no logic.
`ifndef ICD_REGS_VH
`define ICD_REGS_VH

// Register indices. The byte address of a register is four times its index.
`define ICD_IDX_BUS_CONTROL      8'hf0
`define ICD_IDX_STATUS_ONE       8'hf1
`define ICD_IDX_STATUS_TWO       8'hf2
`define ICD_IDX_CLK_DIV_LOW      8'hf3
`define ICD_IDX_OWN_ADDR_LOW     8'hf4
`define ICD_IDX_OWN_ADDR_HIGH    8'hf5
`define ICD_IDX_DATA_BYTE        8'hf6
`define ICD_IDX_GEN_CALL_ADDR    8'hf7
`define ICD_IDX_INT_PEND_PRIO    8'hf8
`define ICD_IDX_INT_VECTOR       8'hf9
`define ICD_IDX_RX_DMA_ADDR      8'hfa
`define ICD_IDX_RX_DMA_COUNT     8'hfb
`define ICD_IDX_TX_DMA_ADDR      8'hfc
`define ICD_IDX_TX_DMA_COUNT     8'hfd
`define ICD_IDX_CLK_DIV_HIGH     8'hfe
`define ICD_IDX_INT_DMA_MASK     8'hff

// Bus control fields.
`define ICD_BC_PERIPH_EN         5
`define ICD_BC_GLOBAL_IRQ_EN     0

// Clock divider fields.
`define ICD_CDL_FAST_MODE        7
`define ICD_CDH_USED_MASK        8'h03

// Interrupt pending and priority fields.
`define ICD_IP_DMA_SUSPEND_SEL   7
`define ICD_IP_PRIO_MASK         8'h70
`define ICD_IP_ERR_PEND          2
`define ICD_IP_RX_PEND           1
`define ICD_IP_TX_PEND           0

// Interrupt vector fields and source codes.
`define ICD_IV_BASE_MASK         8'hf8
`define ICD_EV_ERROR             2'h1
`define ICD_EV_RX                2'h2
`define ICD_EV_TX                2'h3

// Interrupt and DMA mask fields.
`define ICD_IM_RX_DMA_EN         7
`define ICD_IM_TX_DMA_EN         6
`define ICD_IM_RX_DONE           5
`define ICD_IM_TX_DONE           4
`define ICD_IM_ERR_MASK          2
`define ICD_IM_RX_MASK           1
`define ICD_IM_TX_MASK           0

// Error flags that hold the error pending bit high.
`define ICD_S1_ERR_MASK          8'h05
`define ICD_S2_ERR_MASK          8'h3e

// Reset values.
`define ICD_RST_ZERO             8'h00
`define ICD_RST_GEN_CALL         8'ha0
`define ICD_RST_INT_PEND_PRIO    8'h80

`endif

// [rtl/icd_clk_div.v]
// Bus clock divider: a one-cycle tick every divisor+1 clocks.
// Assumes a synchronous active-low reset copy from the top module.
`timescale 1ns/100ps

module icd_clk_div (
   // Clock and reset
   input  wire       mclk,
   input  wire       rst_sync_n,
   // Control
   input  wire       enable,
   input  wire [8:0] divisor,
   // Rate enable
   output reg        tick
);

   reg [8:0] count_reg;

   // --------------------------------------------------------------
   // Counter
   // --------------------------------------------------------------
   // The count restarts whenever the interface is off, so the first tick
   // after enabling comes a full period later.
   always @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count_reg <= 9'h000;
         tick      <= 1'b0;
      end else if (!enable) begin
         count_reg <= 9'h000;
         tick      <= 1'b0;
      end else if (count_reg >= divisor) begin
         count_reg <= 9'h000;
         tick      <= 1'b1;
      end else begin
         count_reg <= count_reg + 9'h001;
         tick      <= 1'b0;
      end
   end

endmodule

// [rtl/icd_top.v]
// Register file, interrupt and DMA gating of the serial bus interface,
// reached over AHB-Lite.
// Assumes the protocol engine and DMA controller share mclk and deliver
// one-cycle event pulses and status levels on that clock.
// How it works
// R1: Nine-bit divisor from high and low bits.
// R2: Disabling the interface keeps upper divider bits.
// R3: Software writes zero to reserved divider bits.
// R4: Receive DMA enable, cleared at counter zero.
// R5: Transmit DMA enable, cleared at counter zero.
// R6: Receive done flag; write zero clears.
// R7: Transmit done flag; write zero clears.
// R8: Software clears done flags at init.
// R9: Software writes zero to mask bit three.
// R10: Error mask gates the error interrupt.
// R11: Receive mask gates data and done interrupts.
// R12: Transmit mask gates ready and done interrupts.
// R13: Masks gate interrupts only, not DMA.
// R14: Mask register resets with masks cleared.
// R15: Upper divider register resets to zero.
// R16: Pending bits clear by zero, ignore one.
// R17: Suspended mode blocks DMA on error pending.
// R18: Interrupt needs flag, mask and global enable.
`timescale 1ns/100ps
`include "icd_regs.vh"

module icd_top (
   // Clock and reset
   input  wire        mclk,
   input  wire        rst_n,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // Protocol engine status and events
   input  wire [7:0]  status_one_in,
   input  wire [7:0]  status_two_in,
   input  wire        error_event,
   input  wire        rx_event,
   input  wire        tx_event,
   // DMA controller side
   input  wire        rx_dma_ready,
   input  wire        tx_dma_ready,
   input  wire        rx_count_zero,
   input  wire        tx_count_zero,
   output reg         rx_dma_req,
   output reg         tx_dma_req,
   output wire [31:0] dma_pointers,
   // Configuration toward the protocol engine
   output wire [7:0]  bus_control_out,
   output wire [8:0]  divisor,
   output wire        fast_mode,
   output wire        scl_tick,
   output wire [15:0] own_address,
   output wire [7:0]  general_call_out,
   output wire [7:0]  data_byte_out,
   output wire [7:0]  vector_out,
   // Interrupt
   output reg         irq
);

   // --------------------------------------------------------------
   // Reset release
   // --------------------------------------------------------------
   reg rst_meta_reg;
   reg rst_sync_n;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   // Hardware set wins over a software clear by zero; a one written
   // leaves the flag as it was.
   function clear_on_zero;
      input old_bit;
      input wr_en;
      input wr_bit;
      input set_bit;
      begin
         clear_on_zero = set_bit | (old_bit & ~(wr_en & ~wr_bit));
      end
   endfunction

   // --------------------------------------------------------------
   // Bus slave
   // --------------------------------------------------------------
   reg        wr_pend_reg;
   reg        rd_pend_reg;
   reg [7:0]  dph_idx_reg;
   reg        dph_hit_reg;
   wire       addr_take;
   wire       addr_hit;
   wire [7:0] wdata;

   assign addr_take = hsel & hready & htrans[1];
   assign addr_hit  = (haddr[31:10] == 22'h000000) && (haddr[9:6] == 4'hf) && (haddr[1:0] == 2'h0);
   assign wdata     = hwdata[7:0];
   // Reads take one wait state so that a write just before is visible.
   assign hreadyout = ~rd_pend_reg;
   assign hresp     = 1'b0;

   always @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         dph_idx_reg <= 8'h00;
         dph_hit_reg <= 1'b0;
      end else begin
         if (hreadyout) begin
            wr_pend_reg <= addr_take & hwrite;
            rd_pend_reg <= addr_take & ~hwrite;
            if (addr_take) begin
               dph_idx_reg <= haddr[9:2];
               dph_hit_reg <= addr_hit;
            end
         end else begin
            rd_pend_reg <= 1'b0;
         end
      end
   end

   function wr_sel;
      input [7:0] idx;
      input       pend;
      input       hit;
      input [7:0] cur;
      begin
         wr_sel = pend & hit & (cur == idx);
      end
   endfunction

   wire wr_bc   = wr_sel(`ICD_IDX_BUS_CONTROL,   wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_cdl  = wr_sel(`ICD_IDX_CLK_DIV_LOW,   wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_oal  = wr_sel(`ICD_IDX_OWN_ADDR_LOW,  wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_oah  = wr_sel(`ICD_IDX_OWN_ADDR_HIGH, wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_dat  = wr_sel(`ICD_IDX_DATA_BYTE,     wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_gca  = wr_sel(`ICD_IDX_GEN_CALL_ADDR, wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_ipp  = wr_sel(`ICD_IDX_INT_PEND_PRIO, wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_ivr  = wr_sel(`ICD_IDX_INT_VECTOR,    wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_rda  = wr_sel(`ICD_IDX_RX_DMA_ADDR,   wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_rdc  = wr_sel(`ICD_IDX_RX_DMA_COUNT,  wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_tda  = wr_sel(`ICD_IDX_TX_DMA_ADDR,   wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_tdc  = wr_sel(`ICD_IDX_TX_DMA_COUNT,  wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_cdh  = wr_sel(`ICD_IDX_CLK_DIV_HIGH,  wr_pend_reg, dph_hit_reg, dph_idx_reg);
   wire wr_imr  = wr_sel(`ICD_IDX_INT_DMA_MASK,  wr_pend_reg, dph_hit_reg, dph_idx_reg);

   // --------------------------------------------------------------
   // Plain storage registers
   // --------------------------------------------------------------
   reg [7:0] bus_control_reg;
   reg [7:0] clk_div_low_reg;
   reg [7:0] clk_div_high_reg;
   reg [7:0] own_addr_low_reg;
   reg [7:0] own_addr_high_reg;
   reg [7:0] data_byte_reg;
   reg [7:0] gen_call_reg;
   reg [7:0] vector_base_reg;
   reg [7:0] rx_dma_addr_reg;
   reg [7:0] rx_dma_count_reg;
   reg [7:0] tx_dma_addr_reg;
   reg [7:0] tx_dma_count_reg;
   wire      peripheral_enable;

   assign peripheral_enable = bus_control_reg[`ICD_BC_PERIPH_EN];

   always @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bus_control_reg   <= `ICD_RST_ZERO;
         clk_div_low_reg   <= `ICD_RST_ZERO;
         clk_div_high_reg  <= `ICD_RST_ZERO; // R15
         own_addr_low_reg  <= `ICD_RST_ZERO;
         own_addr_high_reg <= `ICD_RST_ZERO;
         data_byte_reg     <= `ICD_RST_ZERO;
         gen_call_reg      <= `ICD_RST_GEN_CALL;
         vector_base_reg   <= `ICD_RST_ZERO;
         rx_dma_addr_reg   <= `ICD_RST_ZERO;
         rx_dma_count_reg  <= `ICD_RST_ZERO;
         tx_dma_addr_reg   <= `ICD_RST_ZERO;
         tx_dma_count_reg  <= `ICD_RST_ZERO;
      end else begin
         if (wr_bc) bus_control_reg <= wdata;
         if (wr_cdl) clk_div_low_reg <= wdata;
         // Only the two divider bits are stored, and nothing else touches
         // them, so turning the interface off leaves them in place.
         if (wr_cdh) clk_div_high_reg <= wdata & `ICD_CDH_USED_MASK; // R2 R3
         if (wr_oal) own_addr_low_reg <= wdata;
         if (wr_oah) own_addr_high_reg <= wdata;
         if (wr_dat) data_byte_reg <= wdata;
         // The general call address is locked while the interface runs.
         if (wr_gca && !peripheral_enable) gen_call_reg <= wdata;
         if (wr_ivr) vector_base_reg <= wdata & `ICD_IV_BASE_MASK;
         if (wr_rda) rx_dma_addr_reg <= wdata;
         if (wr_rdc) rx_dma_count_reg <= wdata;
         if (wr_tda) tx_dma_addr_reg <= wdata;
         if (wr_tdc) tx_dma_count_reg <= wdata;
      end
   end

   assign bus_control_out  = bus_control_reg;
   assign divisor          = {clk_div_high_reg[1:0], clk_div_low_reg[6:0]}; // R1
   assign fast_mode        = clk_div_low_reg[`ICD_CDL_FAST_MODE];
   assign own_address      = {own_addr_high_reg, own_addr_low_reg};
   assign general_call_out = gen_call_reg;
   assign data_byte_out    = data_byte_reg;
   assign dma_pointers     = {tx_dma_count_reg, tx_dma_addr_reg, rx_dma_count_reg, rx_dma_addr_reg};

   icd_clk_div u_clk_div (
      .mclk       (mclk),
      .rst_sync_n (rst_sync_n),
      .enable     (peripheral_enable),
      .divisor    (divisor),
      .tick       (scl_tick)
   );

   // --------------------------------------------------------------
   // Pending, priority and mask registers
   // --------------------------------------------------------------
   reg        dma_suspend_sel_reg;
   reg [2:0]  prio_reg;
   reg        error_pending_reg;
   reg        rx_pending_reg;
   reg        tx_pending_reg;
   reg        receive_dma_enable_reg;
   reg        transmit_dma_enable_reg;
   reg        receive_block_done_flag_reg;
   reg        transmit_block_done_flag_reg;
   reg        error_irq_mask_reg;
   reg        receive_irq_mask_reg;
   reg        transmit_irq_mask_reg;
   wire       error_flags_any;
   wire       global_irq_enable;

   assign error_flags_any   = |(status_one_in & `ICD_S1_ERR_MASK) | |(status_two_in & `ICD_S2_ERR_MASK);
   assign global_irq_enable = bus_control_reg[`ICD_BC_GLOBAL_IRQ_EN];

   always @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dma_suspend_sel_reg          <= 1'b1;
         prio_reg                     <= 3'h0;
         error_pending_reg            <= 1'b0;
         rx_pending_reg               <= 1'b0;
         tx_pending_reg               <= 1'b0;
         receive_dma_enable_reg       <= 1'b0; // R14
         transmit_dma_enable_reg      <= 1'b0; // R14
         receive_block_done_flag_reg  <= 1'b0;
         transmit_block_done_flag_reg <= 1'b0;
         error_irq_mask_reg           <= 1'b0; // R14
         receive_irq_mask_reg         <= 1'b0; // R14
         transmit_irq_mask_reg        <= 1'b0; // R14
      end else begin
         if (wr_ipp) dma_suspend_sel_reg <= wdata[`ICD_IP_DMA_SUSPEND_SEL];
         if (wr_ipp) prio_reg <= wdata[6:4];
         // Error pending cannot be cleared while any error flag stands.
         error_pending_reg <= clear_on_zero(error_pending_reg, wr_ipp, wdata[`ICD_IP_ERR_PEND],
                                            error_event | error_flags_any); // R16
         rx_pending_reg    <= clear_on_zero(rx_pending_reg, wr_ipp, wdata[`ICD_IP_RX_PEND], rx_event); // R16
         tx_pending_reg    <= clear_on_zero(tx_pending_reg, wr_ipp, wdata[`ICD_IP_TX_PEND], tx_event); // R16
         receive_block_done_flag_reg  <= clear_on_zero(receive_block_done_flag_reg, wr_imr,
                                                       wdata[`ICD_IM_RX_DONE], rx_count_zero); // R6
         transmit_block_done_flag_reg <= clear_on_zero(transmit_block_done_flag_reg, wr_imr,
                                                       wdata[`ICD_IM_TX_DONE], tx_count_zero); // R7
         // The end of a block outranks a software write of the enable.
         if (rx_count_zero) receive_dma_enable_reg <= 1'b0; // R4
         else if (wr_imr) receive_dma_enable_reg <= wdata[`ICD_IM_RX_DMA_EN]; // R4
         if (tx_count_zero) transmit_dma_enable_reg <= 1'b0; // R5
         else if (wr_imr) transmit_dma_enable_reg <= wdata[`ICD_IM_TX_DMA_EN]; // R5
         if (wr_imr) error_irq_mask_reg <= wdata[`ICD_IM_ERR_MASK];
         if (wr_imr) receive_irq_mask_reg <= wdata[`ICD_IM_RX_MASK];
         if (wr_imr) transmit_irq_mask_reg <= wdata[`ICD_IM_TX_MASK];
      end
   end

   // --------------------------------------------------------------
   // Interrupt and DMA requests
   // --------------------------------------------------------------
   wire err_irq_src;
   wire rx_irq_src;
   wire tx_irq_src;
   wire dma_blocked;
   wire [1:0] source_code;

   assign err_irq_src = error_pending_reg & error_irq_mask_reg; // R10
   assign rx_irq_src  = (rx_pending_reg | receive_block_done_flag_reg) & receive_irq_mask_reg; // R11
   assign tx_irq_src  = (tx_pending_reg | transmit_block_done_flag_reg) & transmit_irq_mask_reg; // R12
   // A set suspend selector bit means not-suspended mode.
   assign dma_blocked = ~dma_suspend_sel_reg & error_pending_reg; // R17

   assign source_code = err_irq_src ? `ICD_EV_ERROR : (rx_irq_src ? `ICD_EV_RX : `ICD_EV_TX);

   // The interrupt masks do not enter the DMA terms at all.
   always @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq        <= 1'b0;
         rx_dma_req <= 1'b0;
         tx_dma_req <= 1'b0;
      end else begin
         irq        <= global_irq_enable & (err_irq_src | rx_irq_src | tx_irq_src); // R18
         rx_dma_req <= receive_dma_enable_reg & rx_dma_ready & ~rx_count_zero & ~dma_blocked; // R13 R17
         tx_dma_req <= transmit_dma_enable_reg & tx_dma_ready & ~tx_count_zero & ~dma_blocked; // R13 R17
      end
   end

   assign vector_out = {vector_base_reg[7:3], source_code, 1'b0};

   // --------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------
   reg [7:0] rd_byte;

   always @* begin
      rd_byte = 8'h00;
      if (dph_hit_reg) begin
         case (dph_idx_reg)
            `ICD_IDX_BUS_CONTROL:   rd_byte = bus_control_reg;
            `ICD_IDX_STATUS_ONE:    rd_byte = status_one_in;
            `ICD_IDX_STATUS_TWO:    rd_byte = status_two_in;
            `ICD_IDX_CLK_DIV_LOW:   rd_byte = clk_div_low_reg;
            `ICD_IDX_OWN_ADDR_LOW:  rd_byte = own_addr_low_reg;
            `ICD_IDX_OWN_ADDR_HIGH: rd_byte = own_addr_high_reg;
            `ICD_IDX_DATA_BYTE:     rd_byte = data_byte_reg;
            `ICD_IDX_GEN_CALL_ADDR: rd_byte = gen_call_reg;
            `ICD_IDX_INT_PEND_PRIO: rd_byte = {dma_suspend_sel_reg, prio_reg, 1'b0,
                                               error_pending_reg, rx_pending_reg, tx_pending_reg};
            `ICD_IDX_INT_VECTOR:    rd_byte = vector_out;
            `ICD_IDX_RX_DMA_ADDR:   rd_byte = rx_dma_addr_reg;
            `ICD_IDX_RX_DMA_COUNT:  rd_byte = rx_dma_count_reg;
            `ICD_IDX_TX_DMA_ADDR:   rd_byte = tx_dma_addr_reg;
            `ICD_IDX_TX_DMA_COUNT:  rd_byte = tx_dma_count_reg;
            `ICD_IDX_CLK_DIV_HIGH:  rd_byte = clk_div_high_reg;
            `ICD_IDX_INT_DMA_MASK:  rd_byte = {receive_dma_enable_reg, transmit_dma_enable_reg,
                                               receive_block_done_flag_reg, transmit_block_done_flag_reg,
                                               1'b0, error_irq_mask_reg, receive_irq_mask_reg,
                                               transmit_irq_mask_reg};
            default:                rd_byte = 8'h00;
         endcase
      end
   end

   always @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hrdata <= 32'h00000000;
      end else if (rd_pend_reg) begin
         hrdata <= {24'h000000, rd_byte};
      end
   end

endmodule

// [verif/icd_top_monitor.sv]
// Concurrent checks on the ports of icd_top, bound to every instance.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps

module icd_top_monitor (
   // Clock, reset and bus
   input wire       mclk,
   input wire       rst_n,
   input wire       hsel,
   input wire [1:0] htrans,
   input wire       hwrite,
   input wire       hreadyout,
   input wire       hresp,
   // DMA, divider and interrupt
   input wire       rx_dma_ready,
   input wire       tx_dma_ready,
   input wire       rx_count_zero,
   input wire       tx_count_zero,
   input wire       rx_dma_req,
   input wire       tx_dma_req,
   input wire [7:0] bus_control_out,
   input wire [8:0] divisor,
   input wire       scl_tick,
   input wire       irq
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_bus_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
   a_read_wait: assert property (hsel && hreadyout && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (hsel && hreadyout && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled");
   a_rx_dma_stop: assert property (rx_count_zero |=> !rx_dma_req [*2])
      else $error("receive request after block end");
   a_tx_dma_stop: assert property (tx_count_zero |=> !tx_dma_req [*2])
      else $error("transmit request after block end");
   a_rx_req_cause: assert property (rx_dma_req |-> $past(rx_dma_ready) && !$past(rx_count_zero))
      else $error("receive request without cause");
   a_tx_req_cause: assert property (tx_dma_req |-> $past(tx_dma_ready) && !$past(tx_count_zero))
      else $error("transmit request without cause");
   a_div_kept: assert property ($fell(bus_control_out[5]) |-> $stable(divisor))
      else $error("divider changed on disable");
   a_tick_off: assert property (!bus_control_out[5] |=> !scl_tick)
      else $error("tick while disabled");
   a_tick_spacing: assert property (scl_tick && divisor != 9'h0 ##1 $stable(divisor) |-> !scl_tick)
      else $error("ticks too close");
   a_irq_global: assert property (irq |-> $past(bus_control_out[0]))
      else $error("interrupt without global enable");
endmodule

bind icd_top icd_top_monitor mon (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hreadyout(hreadyout), .hresp(hresp), .rx_dma_ready(rx_dma_ready), .tx_dma_ready(tx_dma_ready),
   .rx_count_zero(rx_count_zero), .tx_count_zero(tx_count_zero), .rx_dma_req(rx_dma_req),
   .tx_dma_req(tx_dma_req), .bus_control_out(bus_control_out), .divisor(divisor), .scl_tick(scl_tick),
   .irq(irq));

// [verif/icd_engine_model.sv]
// Stand-in for the protocol engine and DMA controller beside icd_top.
// Assumes the bench asks for event pulses through a kick vector on mclk.
`timescale 1ns/100ps

module icd_engine_model (
   // Clock and requests from the bench
   input  wire       mclk,
   input  wire [4:0] kick,
   input  wire       want_rx,
   input  wire       want_tx,
   // Toward the design
   output reg        error_event,
   output reg        rx_event,
   output reg        tx_event,
   output reg        rx_count_zero,
   output reg        tx_count_zero,
   output reg        rx_dma_ready,
   output reg        tx_dma_ready,
   output wire [7:0] status_one_in,
   output wire [7:0] status_two_in
);
   // Error flags stay clear, otherwise software could never clear error pending.
   assign status_one_in = 8'h00;
   assign status_two_in = 8'h00;
   initial begin
      {error_event, rx_event, tx_event, rx_count_zero, tx_count_zero} = 5'h00;
      {rx_dma_ready, tx_dma_ready} = 2'h0;
   end
   always @(posedge mclk) begin
      {error_event, rx_event, tx_event, rx_count_zero, tx_count_zero} <= kick;
      rx_dma_ready <= want_rx;
      tx_dma_ready <= want_tx;
   end
endmodule

// [verif/test_i2c_dma_interrupt_control.sv]
// Self-checking bench for icd_top.
// Assumes icd_engine_model stands in for the engine and DMA side.
`timescale 1ns/100ps

module test_i2c_dma_interrupt_control;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [4:0]  kick = 5'h00;
   logic        want_rx = 1'b0;
   logic        want_tx = 1'b0;
   logic [31:0] seed = 32'd31495;
   logic [7:0]  lo, hi, v;
   int          fail_count = 0, comparisons = 0, cycles = 0, ticks = 0;
   wire         hreadyout, hresp, rx_dma_req, tx_dma_req, irq, err_ev, rx_ev, tx_ev, rxz, txz, rxr, txr, tick;
   wire [8:0]   dma_req = {7'h0, rx_dma_req, tx_dma_req}, irq_v = {8'h0, irq};
   wire [31:0]  hrdata;
   wire [7:0]   st1, st2, bus_control_out;
   wire [8:0]   divisor;

   icd_engine_model peer (.mclk(mclk), .kick(kick), .want_rx(want_rx), .want_tx(want_tx), .error_event(err_ev),
      .rx_event(rx_ev), .tx_event(tx_ev), .rx_count_zero(rxz), .tx_count_zero(txz), .rx_dma_ready(rxr),
      .tx_dma_ready(txr), .status_one_in(st1), .status_two_in(st2));
   icd_top dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .status_one_in(st1), .status_two_in(st2), .error_event(err_ev), .rx_event(rx_ev), .tx_event(tx_ev),
      .rx_dma_ready(rxr), .tx_dma_ready(txr), .rx_count_zero(rxz), .tx_count_zero(txz), .rx_dma_req(rx_dma_req),
      .tx_dma_req(tx_dma_req), .dma_pointers(), .bus_control_out(bus_control_out), .divisor(divisor),
      .fast_mode(), .scl_tick(tick), .own_address(), .general_call_out(), .data_byte_out(), .vector_out(), .irq(irq));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   always #2 mclk = ~mclk;

   function logic [7:0] rnd8();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function logic [31:0] ra(input logic [7:0] idx);
      return {22'h0, idx, 2'h0};
   endfunction
   function logic [7:0] reset_val(input logic [7:0] idx);
      return idx == 8'hf7 ? 8'ha0 : idx == 8'hf8 ? 8'h80 : idx == 8'hf9 ? 8'h06 : 8'h00;
   endfunction

   task close_out();
      if (fail_count == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task bus(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [7:0] rd);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
      hsel <= 1'b0;
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, ra(idx), d, v);
      repeat (2) @(posedge mclk);
   endtask
   task rdc(input logic [31:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, v);
      check("read", {1'b0, v}, {1'b0, e});
   endtask
   task pulse(input logic [4:0] k);
      @(posedge mclk);
      kick <= k;
      @(posedge mclk);
      kick <= 5'h00;
      repeat (3) @(posedge mclk);
   endtask

   always @(posedge mclk) begin
      cycles++;
      ticks += tick;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 240; i < 256; i++) rdc(ra(i[7:0]), reset_val(i[7:0]));
      rdc(32'h0, 8'h00);
      for (int k = 0; k < 4; k++) begin
         lo = rnd8();
         hi = rnd8() & 8'h03;
         wr(8'hf3, lo);
         wr(8'hfe, hi);
         check("divisor", divisor, {hi[1:0], lo[6:0]});
      end
      wr(8'hf0, 8'h21);
      repeat (600) @(posedge mclk);
      wr(8'hf0, 8'h01);
      rdc(ra(8'hfe), hi);
      check("divisor", divisor, {hi[1:0], lo[6:0]});
      check("ticks", ticks[8:0], 9'(605 / ({hi[1:0], lo[6:0]} + 1)));
      wr(8'hff, 8'h00);
      wr(8'hff, 8'hc3);
      pulse(5'h01);
      rdc(ra(8'hff), 8'h93);
      check("irq", irq_v, 9'h1);
      wr(8'hff, 8'h33);
      rdc(ra(8'hff), 8'h13);
      wr(8'hff, 8'h03);
      check("irq", irq_v, 9'h0);
      wr(8'hff, 8'h83);
      pulse(5'h02);
      rdc(ra(8'hff), 8'h23);
      check("irq", irq_v, 9'h1);
      wr(8'hff, 8'h20);
      check("irq", irq_v, 9'h0);
      wr(8'hff, 8'h00);
      pulse(5'h0c);
      rdc(ra(8'hf8), 8'h83);
      wr(8'hf8, 8'h87);
      rdc(ra(8'hf8), 8'h83);
      wr(8'hf8, 8'h80);
      rdc(ra(8'hf8), 8'h80);
      wr(8'hff, 8'hc0);
      want_rx <= 1'b1;
      want_tx <= 1'b1;
      repeat (3) @(posedge mclk);
      check("dma", dma_req, 9'h3);
      pulse(5'h10);
      check("dma", dma_req, 9'h3);
      wr(8'hff, 8'hc4);
      check("irq", irq_v, 9'h1);
      wr(8'hf8, 8'h04);
      check("dma", dma_req, 9'h0);
      wr(8'hf8, 8'h00);
      check("dma", dma_req, 9'h3);
      check("irq", irq_v, 9'h0);
      pulse(5'h03);
      check("dma", dma_req, 9'h0);
      close_out();
   end
endmodule
